/* File: core/tts_core.sv */
// Travel target shaping core with AXI4-Lite register slave
`timescale 1ns/1ps
module tts_core
    import tts_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYC,
    parameter int FILT_CYCLES = FILT_CYC
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // AXI4-Lite write address
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Process side
    input wire logic [15:0] SETPOINT,
    input wire logic [15:0] TRAVEL,
    input wire logic DIAG_ACTIVE,
    // Servo side
    output logic [15:0] TRAVEL_TARGET,
    output tts_gain_t GAINS,
    output logic [7:0] DAMPING,
    output logic [15:0] INTEG_GAIN,
    output logic INTEG_ACTIVE,
    output logic OUT_FORCE_ZERO,
    output logic OUT_FORCE_FULL,
    // Alert gating
    output logic ALERT_EVAL_EN,
    output logic [15:0] ALERT_CFG
);
    typedef enum logic [2:0] {
        S_IDLE, S_SRCH, S_ISET, S_IDIV, S_LIM, S_RDIV, S_RATE
    } tts_state_t;

    typedef struct packed {
        logic aw_rdy, w_rdy, ar_rdy, aw_ok, w_ok, bv, rv;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic [1:0] br, rr;
        logic [31:0] rd;
        logic [3:0] preset;
        logic expert, zero_input_position, ien, prot;
        logic [1:0] chr;
        logic [23:0] xg;
        logic [15:0] ftau;
        logic edit;
        logic [4:0] eidx;
        logic [20:0][15:0] csp, ctt;
        logic [15:0] lhi, llo, chi, clo, topen, tclose;
        logic [15:0] igain, idz, acfg;
        logic [7:0] damp;
        logic [31:0] scnt;
        logic [39:0] fcnt;
        logic [15:0] filt, x, goal;
        tts_state_t state;
        logic [4:0] k, seg;
        logic [31:0] dn;
        logic [15:0] dd;
        logic [16:0] drem;
        logic [4:0] dcnt;
        logic neg;
        logic [23:0] tq;
        tts_gain_t gains;
        logic integ, fzero, ffull, aeval, cuth;
    } tts_st_t;

    tts_st_t st_ff, nxt_st;
    logic [20:0][15:0] psp, ptt;
    logic [33:0] rdr;
    logic [31:0] rold, wv;
    logic [1:0] wr;
    logic [16:0] d17, r2;
    logic [33:0] prod;
    logic [15:0] g, tmr;
    logic [24:0] tsum;
    logic [4:0] ei;

    function automatic logic [33:0] rdmux(input tts_st_t s,
                                          input logic [7:0] a);
        logic [31:0] d;
        logic [1:0] r;
        logic [4:0] i;
        d = '0;
        r = R_OKAY;
        i = s.eidx - 5'h01;
        case (a)
            A_CTRL: d = {22'h0, s.prot, s.ien, s.chr,
                         s.zero_input_position, s.expert, s.preset};
            A_XGAIN: d = {8'h00, s.xg};
            A_FTAU: d = {16'h0000, s.ftau};
            A_EIDX: d = {26'h0, s.edit, s.eidx};
            A_EPT: d = s.edit ? {s.ctt[i], s.csp[i]} : 32'h0000_0000;
            A_LHI: d = {16'h0000, s.lhi};
            A_LLO: d = {16'h0000, s.llo};
            A_CHI: d = {16'h0000, s.chi};
            A_CLO: d = {16'h0000, s.clo};
            A_TOPEN: d = {16'h0000, s.topen};
            A_TCLOSE: d = {16'h0000, s.tclose};
            A_INTEG: d = {s.idz, s.igain};
            A_DAMP: d = {24'h0, s.damp};
            A_ACFG: d = {16'h0000, s.acfg};
            A_STAT: d = {26'h0, s.ffull, s.fzero, s.cuth, s.integ,
                         s.aeval, s.edit};
            A_TGT: d = {16'h0000, s.tq[23:8]};
            default: r = R_DECERR;
        endcase
        return {r, d};
    endfunction : rdmux

    // Selected characterization points
    always_comb begin
        for (int i = 0; i < 21; i++) begin
            psp[i] = 16'(i) * P_STEP;
            ptt[i] = 16'(i) * P_STEP;
            case (st_ff.chr)
                CH_EQ: ptt[i] = EQ_TT[i];
                CH_QO: ptt[i] = P_FULL - EQ_TT[20 - i];
                CH_CUS: begin
                    psp[i] = st_ff.csp[i];
                    ptt[i] = st_ff.ctt[i];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        nxt_st = st_ff;
        rold = '0;
        wv = '0;
        wr = R_OKAY;
        d17 = '0;
        r2 = '0;
        prod = '0;
        g = '0;
        tmr = '0;
        tsum = '0;
        ei = st_ff.eidx - 5'h01;
        rdr = rdmux(st_ff, S_AXI_ARADDR);

        // Bus channels
        if (S_AXI_AWVALID && st_ff.aw_rdy) begin
            nxt_st.aw_ok = 1'b1;
            nxt_st.awa = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && st_ff.w_rdy) begin
            nxt_st.w_ok = 1'b1;
            nxt_st.wd = S_AXI_WDATA;
            nxt_st.ws = S_AXI_WSTRB;
        end
        if (st_ff.bv && S_AXI_BREADY) begin
            nxt_st.bv = 1'b0;
        end
        if (st_ff.rv && S_AXI_RREADY) begin
            nxt_st.rv = 1'b0;
        end
        if (S_AXI_ARVALID && st_ff.ar_rdy) begin
            nxt_st.rv = 1'b1;
            nxt_st.rr = rdr[33:32];
            nxt_st.rd = rdr[31:0];
        end

        // Register write
        if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bv) begin
            rold = 32'(rdmux(st_ff, st_ff.awa));
            for (int b = 0; b < 4; b++) begin
                wv[8*b +: 8] = st_ff.ws[b] ? st_ff.wd[8*b +: 8]
                                           : rold[8*b +: 8];
            end
            if (st_ff.prot && st_ff.awa != A_CTRL
                && st_ff.awa != A_ACFG) begin
                wr = R_SLVERR;
            end else begin
                case (st_ff.awa)
                    A_CTRL: begin
                        nxt_st.preset = (wv[3:0] > NPRE_MAX) ? NPRE_MAX
                                                             : wv[3:0];
                        nxt_st.expert = wv[4];
                        nxt_st.zero_input_position = wv[5];
                        nxt_st.chr = wv[7:6];
                        nxt_st.ien = wv[8];
                        nxt_st.prot = wv[9];
                    end
                    A_XGAIN: nxt_st.xg = wv[23:0];
                    A_FTAU: nxt_st.ftau = wv[15:0];
                    A_EIDX: begin
                        if (wv[4:0] == 5'h00) begin
                            nxt_st.edit = 1'b0;
                        end else if (wv[4:0] <= NPTS) begin
                            nxt_st.edit = 1'b1;
                            nxt_st.eidx = wv[4:0];
                        end else begin
                            wr = R_SLVERR;
                        end
                    end
                    A_EPT: begin
                        if (!st_ff.edit) begin
                            wr = R_SLVERR;
                        end else begin
                            g = wv[15:0];
                            if ($signed(g) < $signed(P_SP_MIN)) begin
                                g = P_SP_MIN;
                            end
                            if ($signed(g) > $signed(P_SP_MAX)) begin
                                g = P_SP_MAX;
                            end
                            nxt_st.csp[ei] = g;
                            nxt_st.ctt[ei] = wv[31:16];
                        end
                    end
                    A_LHI: begin
                        nxt_st.lhi = wv[15:0];
                        if (wv[15:0] != P_OFF_HI) begin
                            nxt_st.chi = P_OFF_HI;
                        end
                    end
                    A_LLO: begin
                        nxt_st.llo = wv[15:0];
                        if (wv[15:0] != P_OFF_LO) begin
                            nxt_st.clo = P_OFF_LO;
                        end
                    end
                    A_CHI: begin
                        nxt_st.chi = wv[15:0];
                        if (wv[15:0] != P_OFF_HI) begin
                            nxt_st.lhi = P_OFF_HI;
                        end
                    end
                    A_CLO: begin
                        nxt_st.clo = wv[15:0];
                        if (wv[15:0] != P_OFF_LO) begin
                            nxt_st.llo = P_OFF_LO;
                        end
                    end
                    A_TOPEN: nxt_st.topen = wv[15:0];
                    A_TCLOSE: nxt_st.tclose = wv[15:0];
                    A_INTEG: begin
                        nxt_st.igain = wv[15:0];
                        nxt_st.idz = wv[31:16];
                    end
                    A_DAMP: nxt_st.damp = wv[7:0];
                    A_ACFG: nxt_st.acfg = wv[15:0];
                    A_STAT, A_TGT: wr = R_SLVERR;
                    default: wr = R_DECERR;
                endcase
            end
            nxt_st.aw_ok = 1'b0;
            nxt_st.w_ok = 1'b0;
            nxt_st.bv = 1'b1;
            nxt_st.br = wr;
        end

        // Sample and filter timebases
        nxt_st.scnt = st_ff.scnt + 32'h0000_0001;
        if (st_ff.scnt >= 32'(SAMPLE_CYCLES - 1)) begin
            nxt_st.scnt = '0;
        end
        nxt_st.fcnt = st_ff.fcnt + 40'h00_0000_0001;
        if (st_ff.ftau == 16'h0000) begin
            nxt_st.fcnt = '0;
            nxt_st.filt = SETPOINT;
        end else if (st_ff.fcnt + 40'h00_0000_0001
                     >= 40'(st_ff.ftau) * 40'(FILT_CYCLES)) begin
            nxt_st.fcnt = '0;
            d17 = {SETPOINT[15], SETPOINT} - {st_ff.filt[15], st_ff.filt};
            nxt_st.filt = st_ff.filt + 16'($signed(d17) >>> 4);
        end

        // Target pipeline
        case (st_ff.state)
            S_IDLE: begin
                if (st_ff.scnt == '0) begin
                    g = st_ff.zero_input_position ? P_FULL - st_ff.filt
                                                  : st_ff.filt;
                    if ($signed(g) < $signed(psp[0])) begin
                        g = psp[0];
                    end
                    if ($signed(g) > $signed(psp[20])) begin
                        g = psp[20];
                    end
                    nxt_st.x = g;
                    nxt_st.k = '0;
                    nxt_st.seg = '0;
                    nxt_st.state = S_SRCH;
                end
            end
            S_SRCH: begin
                if ($signed(st_ff.x) >= $signed(psp[st_ff.k + 5'h01])
                    && st_ff.k < 5'h13) begin
                    nxt_st.seg = st_ff.k + 5'h01;
                end
                nxt_st.k = st_ff.k + 5'h01;
                if (st_ff.k == 5'h13) begin
                    nxt_st.state = S_ISET;
                end
            end
            S_ISET: begin
                d17 = {st_ff.x[15], st_ff.x}
                    - {psp[st_ff.seg][15], psp[st_ff.seg]};
                r2 = {ptt[st_ff.seg + 5'h01][15], ptt[st_ff.seg + 5'h01]}
                   - {ptt[st_ff.seg][15], ptt[st_ff.seg]};
                prod = 34'($signed(d17) * $signed(r2));
                tmr = psp[st_ff.seg + 5'h01] - psp[st_ff.seg];
                nxt_st.dcnt = '0;
                nxt_st.drem = '0;
                nxt_st.neg = prod[33];
                nxt_st.dn = prod[33] ? 32'(-prod) : prod[31:0];
                nxt_st.dd = tmr;
                nxt_st.state = S_IDIV;
                if ($signed(tmr) <= 0) begin
                    nxt_st.dn = '0;
                    nxt_st.state = S_LIM;
                end
            end
            S_IDIV, S_RDIV: begin
                r2 = {st_ff.drem[15:0], st_ff.dn[31]};
                nxt_st.dn = {st_ff.dn[30:0], 1'b0};
                if (r2 >= {1'b0, st_ff.dd}) begin
                    r2 = r2 - {1'b0, st_ff.dd};
                    nxt_st.dn[0] = 1'b1;
                end
                nxt_st.drem = r2;
                nxt_st.dcnt = st_ff.dcnt + 5'h01;
                if (st_ff.dcnt == 5'h1F) begin
                    nxt_st.state = (st_ff.state == S_IDIV) ? S_LIM
                                                           : S_RATE;
                end
            end
            S_LIM: begin
                g = ptt[st_ff.seg] + (st_ff.neg ? 16'(-st_ff.dn)
                                                : st_ff.dn[15:0]);
                nxt_st.cuth = 1'b0;
                if (st_ff.chi != P_OFF_HI
                    && $signed(g) > $signed(st_ff.chi)) begin
                    g = P_CUT_HI;
                    nxt_st.cuth = 1'b1;
                end
                if (st_ff.lhi != P_OFF_HI
                    && $signed(g) > $signed(st_ff.lhi)) begin
                    g = st_ff.lhi;
                end
                if (st_ff.llo != P_OFF_LO
                    && $signed(g) < $signed(st_ff.llo)) begin
                    g = st_ff.llo;
                end
                nxt_st.fzero = 1'b0;
                nxt_st.ffull = 1'b0;
                if (st_ff.clo != P_OFF_LO
                    && $signed(g) < $signed(st_ff.clo)) begin
                    nxt_st.fzero = !st_ff.zero_input_position;
                    nxt_st.ffull = st_ff.zero_input_position;
                end
                nxt_st.goal = g;
                nxt_st.neg = $signed({g, 8'h00}) > $signed(st_ff.tq);
                tmr = nxt_st.neg ? st_ff.topen : st_ff.tclose;
                nxt_st.dn = RATE_NUM;
                nxt_st.dd = tmr;
                nxt_st.drem = '0;
                nxt_st.dcnt = '0;
                nxt_st.state = S_RDIV;
                if (tmr == 16'h0000) begin
                    nxt_st.tq = {g, 8'h00};
                    nxt_st.state = S_IDLE;
                end
            end
            S_RATE: begin
                if (st_ff.neg) begin
                    tsum = {st_ff.tq[23], st_ff.tq} + st_ff.dn[24:0];
                    if ($signed(tsum) > $signed({st_ff.goal[15],
                                                 st_ff.goal, 8'h00})) begin
                        tsum = {st_ff.goal[15], st_ff.goal, 8'h00};
                    end
                    nxt_st.tq = tsum[23:0];
                end else begin
                    tsum = {st_ff.tq[23], st_ff.tq} - st_ff.dn[24:0];
                    if ($signed(tsum) < $signed({st_ff.goal[15],
                                                 st_ff.goal, 8'h00})) begin
                        tsum = {st_ff.goal[15], st_ff.goal, 8'h00};
                    end
                    nxt_st.tq = tsum[23:0];
                end
                nxt_st.state = S_IDLE;
            end
            default: nxt_st.state = S_IDLE;
        endcase

        // Servo outputs, alert gate and bus ready flags
        nxt_st.gains = st_ff.expert ? st_ff.xg
            : {PRE_P[st_ff.preset], PRE_V[st_ff.preset],
               PRE_M[st_ff.preset]};
        d17 = {st_ff.tq[23], st_ff.tq[23:8]} - {TRAVEL[15], TRAVEL};
        if (d17[16]) begin
            d17 = -d17;
        end
        nxt_st.integ = st_ff.ien && st_ff.igain != 16'h0000
            && d17 >= {1'b0, st_ff.idz};
        nxt_st.aeval = !DIAG_ACTIVE;

        nxt_st.aw_rdy = !nxt_st.aw_ok && !nxt_st.bv;
        nxt_st.w_rdy = !nxt_st.w_ok && !nxt_st.bv;
        nxt_st.ar_rdy = !nxt_st.rv;

        if (RESET) begin
            nxt_st = '0;
            nxt_st.lhi = P_OFF_HI;
            nxt_st.chi = P_OFF_HI;
            nxt_st.llo = P_OFF_LO;
            nxt_st.clo = P_OFF_LO;
            nxt_st.state = S_IDLE;
            for (int i = 0; i < 21; i++) begin
                nxt_st.csp[i] = 16'(i) * P_STEP;
                nxt_st.ctt[i] = 16'(i) * P_STEP;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        st_ff <= nxt_st;
    end

    assign S_AXI_AWREADY = st_ff.aw_rdy;
    assign S_AXI_WREADY = st_ff.w_rdy;
    assign S_AXI_BRESP = st_ff.br;
    assign S_AXI_BVALID = st_ff.bv;
    assign S_AXI_ARREADY = st_ff.ar_rdy;
    assign S_AXI_RDATA = st_ff.rd;
    assign S_AXI_RRESP = st_ff.rr;
    assign S_AXI_RVALID = st_ff.rv;
    assign TRAVEL_TARGET = st_ff.tq[23:8];
    assign GAINS = st_ff.gains;
    assign DAMPING = st_ff.damp;
    assign INTEG_GAIN = st_ff.igain;
    assign INTEG_ACTIVE = st_ff.integ;
    assign OUT_FORCE_ZERO = st_ff.fzero;
    assign OUT_FORCE_FULL = st_ff.ffull;
    assign ALERT_EVAL_EN = st_ff.aeval;
    assign ALERT_CFG = st_ff.acfg;
endmodule : tts_core

/* File: inc/tts_pkg.sv */
// Travel target shaping: register map, tables, timing and types
package tts_pkg;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_XGAIN = 8'h04;
    localparam logic [7:0] A_FTAU = 8'h08;
    localparam logic [7:0] A_EIDX = 8'h0C;
    localparam logic [7:0] A_EPT = 8'h10;
    localparam logic [7:0] A_LHI = 8'h14;
    localparam logic [7:0] A_LLO = 8'h18;
    localparam logic [7:0] A_CHI = 8'h1C;
    localparam logic [7:0] A_CLO = 8'h20;
    localparam logic [7:0] A_TOPEN = 8'h24;
    localparam logic [7:0] A_TCLOSE = 8'h28;
    localparam logic [7:0] A_INTEG = 8'h2C;
    localparam logic [7:0] A_DAMP = 8'h30;
    localparam logic [7:0] A_ACFG = 8'h34;
    localparam logic [7:0] A_STAT = 8'h38;
    localparam logic [7:0] A_TGT = 8'h3C;
    // Bus responses
    localparam logic [1:0] R_OKAY = 2'h0;
    localparam logic [1:0] R_SLVERR = 2'h2;
    localparam logic [1:0] R_DECERR = 2'h3;
    // Characterization selector
    localparam logic [1:0] CH_LIN = 2'h0;
    localparam logic [1:0] CH_EQ = 2'h1;
    localparam logic [1:0] CH_QO = 2'h2;
    localparam logic [1:0] CH_CUS = 2'h3;
    // Percent values, 0.01 % per LSB, two's complement
    localparam logic [15:0] P_FULL = 16'h2710;
    localparam logic [15:0] P_OFF_HI = 16'h30D4;
    localparam logic [15:0] P_OFF_LO = 16'hF63C;
    localparam logic [15:0] P_CUT_HI = 16'h300C;
    localparam logic [15:0] P_SP_MIN = 16'hFD8F;
    localparam logic [15:0] P_SP_MAX = 16'h2981;
    localparam logic [15:0] P_STEP = 16'h01F4;
    localparam logic [4:0] NPTS = 5'h15;
    localparam logic [3:0] NPRE_MAX = 4'hA;
    // Preset gains, index 0 slowest, index 10 fastest
    localparam logic [10:0][7:0] PRE_P = {8'h12, 8'h10, 8'h0E, 8'h0C,
        8'h0B, 8'h0A, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05};
    localparam logic [10:0][7:0] PRE_V = {8'h01, 8'h01, 8'h01, 8'h01,
        8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
    localparam logic [10:0][7:0] PRE_M = {8'h23, 8'h23, 8'h26, 8'h29,
        8'h2C, 8'h2E, 8'h31, 8'h34, 8'h37, 8'h37, 8'h37};
    // Equal percentage curve, point 20 first
    localparam logic [20:0][15:0] EQ_TT = {16'h2710, 16'h1FF8, 16'h1A26,
        16'h155D, 16'h116B, 16'h0E31, 16'h0B85, 16'h0954, 16'h0789,
        16'h060F, 16'h04D7, 16'h03D7, 16'h0304, 16'h0257, 16'h01C8,
        16'h0153, 16'h00F3, 16'h00A3, 16'h0062, 16'h002C, 16'h0000};
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int SAMPLE_US = 1000;
    localparam int SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
    localparam int TIME_UNIT_US = 100_000;
    localparam int FILT_SUB_US = TIME_UNIT_US / 16;
    localparam int FILT_CYC = CLK_HZ / 1_000_000 * FILT_SUB_US;
    localparam logic [31:0] RATE_NUM =
        32'(10000 * 256 * SAMPLE_US / TIME_UNIT_US);
    // Servo gain triplet
    typedef struct packed {
        logic [7:0] p;
        logic [7:0] v;
        logic [7:0] m;
    } tts_gain_t;
endpackage : tts_pkg

/* File: sim/tts_asserts.sv */
// Port checker for the travel target shaping core
`timescale 1ns/1ps
module tts_asserts
    import tts_pkg::*;
(
    // Bus
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    // Process
    input wire logic DIAG_ACTIVE,
    input wire logic ALERT_EVAL_EN,
    input wire logic INTEG_ACTIVE,
    input wire logic [15:0] INTEG_GAIN,
    input wire logic OUT_FORCE_ZERO,
    input wire logic OUT_FORCE_FULL
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    sequence s_wr_take;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_b_done;
        S_AXI_BVALID && S_AXI_BREADY;
    endsequence
    chk_wr_answer: assert property (s_wr_take |=> ##1 S_AXI_BVALID)
        else $error("write answer late");
    chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("b dropped");
    chk_b_busy: assert property (S_AXI_BVALID |->
        !S_AXI_AWREADY && !S_AXI_WREADY) else $error("ready in b");
    chk_ready_back: assert property (s_b_done |=>
        !S_AXI_BVALID ##[0:1] S_AXI_AWREADY) else $error("ready stuck");
    chk_ar_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("ar ready in r");
    chk_alert_gate: assert property (
        !$past(RESET) |-> ALERT_EVAL_EN == !$past(DIAG_ACTIVE))
        else $error("alert gate wrong");
    chk_force_one: assert property (
        !(OUT_FORCE_ZERO && OUT_FORCE_FULL)) else $error("both forces");
    chk_integ_gain: assert property (
        INTEG_ACTIVE |-> $past(INTEG_GAIN) != 16'h0000)
        else $error("integ on");
endmodule : tts_asserts
bind tts_core tts_asserts i_tts_asserts (.MCLK, .RESET, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARREADY, .S_AXI_RVALID,
    .DIAG_ACTIVE, .ALERT_EVAL_EN, .INTEG_ACTIVE, .INTEG_GAIN,
    .OUT_FORCE_ZERO, .OUT_FORCE_FULL);

/* File: sim/tts_core_test.sv */
// Register and travel target tests
`timescale 1ns/1ps
module tts_core_test;
    import tts_pkg::*;
    logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [15:0] cmd = 0, sp, tvl, tt, ig, acfg;
    logic awr, wrd, bv, arr, rv, dg, fz, ff, ia, ae;
    logic [1:0] bre, rre;
    logic [7:0] dmp;
    tts_gain_t gn;
    int n_mismatch = 0, num_checks = 0;
    logic [10:0][7:0] pp = {8'h12, 8'h10, 8'h0E, 8'h0C, 8'h0B, 8'h0A,
        8'h09, 8'h08, 8'h07, 8'h06, 8'h05};
    logic [10:0][7:0] pv = {8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h02,
        8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
    logic [10:0][7:0] pm = {8'h23, 8'h23, 8'h26, 8'h29, 8'h2C, 8'h2E,
        8'h31, 8'h34, 8'h37, 8'h37, 8'h37};
    always #25 clk = ~clk;
    tts_core #(.SAMPLE_CYCLES(200), .FILT_CYCLES(16)) i_tts_core (
        .MCLK(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bre),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rre), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
        .SETPOINT(sp), .TRAVEL(tvl), .DIAG_ACTIVE(dg), .TRAVEL_TARGET(tt),
        .GAINS(gn), .DAMPING(dmp), .INTEG_GAIN(ig), .INTEG_ACTIVE(ia),
        .OUT_FORCE_ZERO(fz), .OUT_FORCE_FULL(ff), .ALERT_EVAL_EN(ae),
        .ALERT_CFG(acfg));
    tts_plant i_tts_plant (.clk(clk), .rst(rst), .cmd(cmd), .tgt(tt),
        .sp(sp), .tvl(tvl), .diag(dg));
    task cmp(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        br <= 1'b1;
        @(posedge clk);
        cmp({30'h0, bre}, {30'h0, e});
        br <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        cmp(rdat, d);
        cmp({30'h0, rre}, {30'h0, e});
        rr <= 1'b0;
    endtask : rd
    task stage(input logic [15:0] s, input logic [15:0] e);
        cmd <= s;
        repeat (500) @(posedge clk);
        cmp({16'h0, tt}, {16'h0, e});
    endtask : stage
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    initial begin
        #2_000_000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(A_LHI, 32'h0000_30D4, R_OKAY);
        rd(A_CLO, 32'h0000_F63C, R_OKAY);
        rd(8'hFC, 32'h0000_0000, R_DECERR);
        wr(A_TGT, 32'h0000_0000, R_SLVERR);
        for (int i = 0; i < 11; i++) begin
            wr(A_CTRL, 32'(i), R_OKAY);
            cmp({8'h00, gn}, {8'h00, pp[i], pv[i], pm[i]});
        end
        wr(A_XGAIN, 32'h0011_2233, R_OKAY);
        wr(A_CTRL, 32'h0000_0110, R_OKAY);
        wr(A_INTEG, 32'h0000_0001, R_OKAY);
        cmp({8'h00, gn}, 32'h0011_2233);
        cmp({31'h0, ia}, 32'h0000_0001);
        wr(A_TOPEN, 32'h0000_0000, R_OKAY);
        wr(A_LHI, 32'h0000_1388, R_OKAY);
        stage(16'h1F40, 16'h1388);
        wr(A_CHI, 32'h0000_2328, R_OKAY);
        stage(16'h251C, 16'h300C);
        wr(A_CLO, 32'h0000_0032, R_OKAY);
        stage(16'h0000, 16'h0000);
        cmp({31'h0, fz}, 32'h0000_0001);
        wr(A_CLO, 32'h0000_F63C, R_OKAY);
        wr(A_CTRL, 32'h0000_0120, R_OKAY);
        stage(16'h07D0, 16'h1F40);
        rd(A_CTRL, 32'h0000_0120, R_OKAY);
        wr(A_LLO, 32'h0000_0FA0, R_OKAY);
        stage(16'h2328, 16'h0FA0);
        wr(A_EIDX, 32'h0000_0015, R_OKAY);
        rd(A_EPT, 32'h2710_2710, R_OKAY);
        wr(A_EPT, 32'h1234_7FFF, R_OKAY);
        rd(A_EPT, 32'h1234_2981, R_OKAY);
        wr(A_EIDX, 32'h0000_0000, R_OKAY);
        wr(A_EPT, 32'h0000_0000, R_SLVERR);
        wr(A_CTRL, 32'h0000_01E0, R_OKAY);
        stage(16'h0000, 16'h1CB5);
        wr(A_INTEG, 32'h7FFF_0001, R_OKAY);
        cmp({31'h0, ia}, 32'h0000_0000);
        wr(A_DAMP, 32'h0000_0044, R_OKAY);
        wr(A_CTRL, 32'h0000_03E0, R_OKAY);
        wr(A_ACFG, 32'h0000_5A5A, R_OKAY);
        wr(A_DAMP, 32'h0000_0011, R_SLVERR);
        cmp({24'h0, dmp}, 32'h0000_0044);
        cmp({16'h0, acfg}, 32'h0000_5A5A);
        end_sim;
    end
endmodule : tts_core_test

/* File: sim/tts_plant.sv */
// Process controller and valve model
`timescale 1ns/1ps
module tts_plant (
    // Clock and demand
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] cmd,
    input wire logic [15:0] tgt,
    // Process
    output logic [15:0] sp,
    output logic [15:0] tvl,
    output logic diag
);
    logic [7:0] cnt_ff;
    always_ff @(posedge clk) begin
        cnt_ff <= rst ? 8'h00 : cnt_ff + 8'h01;
        sp <= cmd;
        diag <= cnt_ff[7] & cnt_ff[4];
        if (rst) tvl <= 16'h0000;
        else if ($signed(tvl) < $signed(tgt)) tvl <= tvl + 16'h0010;
        else if ($signed(tvl) > $signed(tgt)) tvl <= tvl - 16'h0001;
    end
endmodule : tts_plant
